// ==== src/lpg_guard.sv ====
// wake-up clock guard around exit from the deep low-power modes
`default_nettype none
`timescale 1ns/100ps

module lpg_guard #(
	parameter int HOLD_NORM_CYC = lpg_pkg::NORM_CYC
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic lpm_wake,
	input wire logic [1:0] core_level,
	input wire logic [2:0] main_clock_divider_field,
	input wire logic sub_src_second_crystal,
	input wire logic low_side_full_performance_bit,
	output logic main_clk_en,
	output logic osc_overshoot,
	output logic sub_clock_fast,
	output logic cpu_hold,
	output logic restore_ready,
	output logic supervisor_reset
);
	localparam logic [15:0] OVS_LD = 16'(lpg_pkg::OVS_CYC);
	localparam logic [15:0] FP_LD = 16'(lpg_pkg::FP_CYC);

	lpg_pkg::lpg_state_t st_r;
	lpg_pkg::lpg_state_t st_nxt;
	logic [15:0] ov_cnt_r;
	logic [15:0] ov_cnt_nxt;
	logic [15:0] hold_cnt_r;
	logic [15:0] hold_cnt_nxt;
	logic [6:0] wait_cnt_r;
	logic [6:0] wait_cnt_nxt;
	logic ready_r;
	logic ready_nxt;
	logic sub_fast_r;
	logic sub_fast_nxt;
	logic [1:0] lvl_r;
	logic [15:0] settle_cnt_r;
	logic [15:0] settle_cnt_nxt;
	logic settle_fp_r;
	logic settle_fp_nxt;
	logic sup_rst_r;
	logic sup_rst_nxt;
	logic raise;

	// level-dependent wake settle count in main clock cycles
	function automatic logic [6:0] lvl_wait(input logic [1:0] lvl);
		case (lvl)
			2'h0: lvl_wait = lpg_pkg::WAIT_LVL0;
			2'h1: lvl_wait = lpg_pkg::WAIT_LVL1;
			2'h2: lvl_wait = lpg_pkg::WAIT_LVL2;
			default: lvl_wait = lpg_pkg::WAIT_LVL3;
		endcase
	endfunction

	// supervisor delay by performance mode
	function automatic logic [15:0] sup_delay(input logic fp);
		sup_delay = fp ? FP_LD : 16'(HOLD_NORM_CYC);
	endfunction

	// main clock runs at the software divider; the divider clamps it to 5 in hardware
	lpg_mclk_div u_div (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.div(main_clock_divider_field),
		.en(main_clk_en)
	);

	// oscillator overshoot window after each wake, and its effect on
	// the sub-system clock; nothing masks it, only the source choice helps
	always_comb
	begin
		ov_cnt_nxt = ov_cnt_r;
		if (lpm_wake)
			ov_cnt_nxt = OVS_LD;
		else if (ov_cnt_r != 16'h0000)
			ov_cnt_nxt = ov_cnt_r - 16'h0001;
		sub_fast_nxt = (ov_cnt_nxt != 16'h0000) && !sub_src_second_crystal;
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ov_cnt_r <= 16'h0000;
			sub_fast_r <= 1'b0;
		end
		else
		begin
			ov_cnt_r <= ov_cnt_nxt;
			sub_fast_r <= sub_fast_nxt;
		end
	end

	// wake sequence: cpu hold-off, then level wait in main clock cycles
	always_comb
	begin
		st_nxt = st_r;
		hold_cnt_nxt = hold_cnt_r;
		wait_cnt_nxt = wait_cnt_r;
		ready_nxt = ready_r;
		case (st_r)
			lpg_pkg::ST_RUN:
			begin
				if (lpm_wake)
				begin
					st_nxt = lpg_pkg::ST_HOLD;
					hold_cnt_nxt = sup_delay(low_side_full_performance_bit);
					ready_nxt = 1'b0;
				end
			end
			lpg_pkg::ST_HOLD:
			begin
				hold_cnt_nxt = hold_cnt_r - 16'h0001;
				if (hold_cnt_r == 16'h0001)
				begin
					st_nxt = lpg_pkg::ST_WAIT;
					wait_cnt_nxt = lvl_wait(core_level);
				end
			end
			lpg_pkg::ST_WAIT:
			begin
				// counted on main clock so it matches what software sees
				if (main_clk_en)
				begin
					wait_cnt_nxt = wait_cnt_r - 7'h01;
					if (wait_cnt_r == 7'h01)
					begin
						st_nxt = lpg_pkg::ST_RUN;
						ready_nxt = 1'b1;
					end
				end
			end
			default:
				st_nxt = lpg_pkg::ST_RUN;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			st_r <= lpg_pkg::ST_RUN;
			hold_cnt_r <= 16'h0000;
			wait_cnt_r <= 7'h00;
			ready_r <= 1'b1;
		end
		else
		begin
			st_r <= st_nxt;
			hold_cnt_r <= hold_cnt_nxt;
			wait_cnt_r <= wait_cnt_nxt;
			ready_r <= ready_nxt;
		end
	end

	// core level raise under the supervisor: the short delay ends before
	// the core has settled, so full performance means a reset
	assign raise = (core_level > lvl_r);

	always_comb
	begin
		settle_cnt_nxt = settle_cnt_r;
		settle_fp_nxt = settle_fp_r;
		sup_rst_nxt = 1'b0;
		if (raise)
		begin
			settle_cnt_nxt = sup_delay(low_side_full_performance_bit);
			settle_fp_nxt = low_side_full_performance_bit;
		end
		else if (settle_cnt_r != 16'h0000)
		begin
			settle_cnt_nxt = settle_cnt_r - 16'h0001;
			sup_rst_nxt = (settle_cnt_r == 16'h0001) && settle_fp_r;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			lvl_r <= 2'h0;
			settle_cnt_r <= 16'h0000;
			settle_fp_r <= 1'b0;
			sup_rst_r <= 1'b0;
		end
		else
		begin
			lvl_r <= core_level;
			settle_cnt_r <= settle_cnt_nxt;
			settle_fp_r <= settle_fp_nxt;
			sup_rst_r <= sup_rst_nxt;
		end
	end

	assign osc_overshoot = (ov_cnt_r != 16'h0000);
	assign sub_clock_fast = sub_fast_r;
	assign cpu_hold = (st_r == lpg_pkg::ST_HOLD);
	assign restore_ready = ready_r;
	assign supervisor_reset = sup_rst_r;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	sequence s_wake_fp;
		lpm_wake && (st_r == lpg_pkg::ST_RUN) && low_side_full_performance_bit;
	endsequence

	property p_ovs_load;
		lpm_wake |=> osc_overshoot && (ov_cnt_r == OVS_LD);
	endproperty
	a_ovs_load: assert property (p_ovs_load) else $error("overshoot not 600");

	property p_ovs_bound;
		osc_overshoot && !lpm_wake |=> ov_cnt_r == $past(ov_cnt_r) - 16'h0001;
	endproperty
	a_ovs_bound: assert property (p_ovs_bound) else $error("overshoot drift");

	property p_sub_fast;
		lpm_wake && !sub_src_second_crystal |=> sub_clock_fast;
	endproperty
	a_sub_fast: assert property (p_sub_fast) else $error("sub clock masked");

	property p_hold_fp;
		s_wake_fp |=> cpu_hold[*8] ##193 !cpu_hold;
	endproperty
	a_hold_fp: assert property (p_hold_fp) else $error("fp hold not 200");

	property p_hold_norm;
		lpm_wake && (st_r == lpg_pkg::ST_RUN) && !low_side_full_performance_bit
			|=> cpu_hold && hold_cnt_r == 16'(HOLD_NORM_CYC);
	endproperty
	a_hold_norm: assert property (p_hold_norm) else $error("normal hold");

	// assertion helper: cycles since the last raise and the mode it saw;
	// kept apart from the settle counter so the check is independent
	logic [15:0] since_raise_r;
	logic [15:0] since_raise_nxt;
	logic raise_fp_r;
	logic raise_fp_nxt;

	// saturates so a long quiet spell never wraps into a false match
	always_comb
	begin
		since_raise_nxt = since_raise_r;
		raise_fp_nxt = raise_fp_r;
		if (raise)
		begin
			since_raise_nxt = 16'h0001;
			raise_fp_nxt = low_side_full_performance_bit;
		end
		else if (since_raise_r != 16'h0000 && since_raise_r != 16'hffff)
			since_raise_nxt = since_raise_r + 16'h0001;
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			since_raise_r <= 16'h0000;
			raise_fp_r <= 1'b0;
		end
		else
		begin
			since_raise_r <= since_raise_nxt;
			raise_fp_r <= raise_fp_nxt;
		end
	end

	property p_fp_reset;
		raise_fp_r && since_raise_r == FP_LD + 16'h0001 |-> supervisor_reset;
	endproperty
	a_fp_reset: assert property (p_fp_reset) else $error("no fp reset");

	property p_fp_delay;
		raise && low_side_full_performance_bit |=> settle_cnt_r == FP_LD;
	endproperty
	a_fp_delay: assert property (p_fp_delay) else $error("fp delay");

	property p_norm_no_reset;
		supervisor_reset |-> $past(settle_fp_r) && !$past(raise);
	endproperty
	a_norm_no_reset: assert property (p_norm_no_reset) else $error("bad reset");
endmodule

`default_nettype wire

// ==== src/lpg_mclk_div.sv ====
// constants and main clock enable divider for the wake-up clock guard
`timescale 1ns/100ps
`default_nettype none

package lpg_pkg;
	localparam int CLK_PERIOD_NS = 10;
	localparam int OVS_US = 6;
	localparam int FP_DELAY_US = 2;
	localparam int NORM_DELAY_US = 150;
	// least times round up, longest times round down
	localparam int OVS_CYC = (OVS_US * 1000) / CLK_PERIOD_NS;
	localparam int FP_CYC = (FP_DELAY_US * 1000 + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int NORM_CYC = (NORM_DELAY_US * 1000 + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam logic [6:0] WAIT_LVL0 = 7'h20;
	localparam logic [6:0] WAIT_LVL1 = 7'h30;
	localparam logic [6:0] WAIT_LVL2 = 7'h50;
	localparam logic [6:0] WAIT_LVL3 = 7'h64;
	localparam logic [2:0] DIV_BY_TWO = 3'h1;
	localparam logic [2:0] DIV_MAX = 3'h5;
	localparam int CNT_W = 16;
	typedef enum logic [1:0] {
		ST_RUN = 2'h0,
		ST_HOLD = 2'h1,
		ST_WAIT = 2'h3
	} lpg_state_t;
endpackage

// main clock enable: one pulse every 2**div cycles, div clamped to 5
module lpg_mclk_div (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic [2:0] div,
	output logic en
);
	logic [4:0] cnt_r;
	logic [4:0] cnt_nxt;
	logic [4:0] mask;
	logic [2:0] d;

	// mask picks the low bits that must wrap before a pulse
	always_comb
	begin
		d = (div > lpg_pkg::DIV_MAX) ? lpg_pkg::DIV_MAX : div;
		mask = ~(5'h1f << d);
		cnt_nxt = cnt_r + 5'h1;
		en = ((cnt_r & mask) == mask);
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			cnt_r <= 5'h00;
		else
			cnt_r <= cnt_nxt;
	end
endmodule

`default_nettype wire

// ==== verification/tb.sv ====
// self-checking bench for the wake-up clock guard
`default_nettype none
`timescale 1ns/100ps

module tb;
	logic ref_clk, rst_b, lpm_wake, fp, xt2;
	logic [1:0] lvl;
	logic [2:0] div;
	logic mce, ovs, sfast, hold, rdy, srst;
	int err_count, checks, n_ovs, n_sf, n_hold, n_pls, first, k;
	int exp_ovs, exp_lo, rdy_k;
	// lvl, fp, xt2, div, rewake, hold cycles, wait pulses
	int rows [4][7] = '{'{0, 1, 0, 0, 0, 200, 32}, '{1, 1, 1, 1, 0, 200, 48},
		'{2, 0, 0, 0, 1, 300, 80}, '{3, 0, 1, 0, 0, 300, 100}};

	lpg_guard #(.HOLD_NORM_CYC(300)) u_lpg_guard (.ref_clk(ref_clk),
		.rst_b(rst_b), .lpm_wake(lpm_wake), .core_level(lvl),
		.main_clock_divider_field(div), .sub_src_second_crystal(xt2),
		.low_side_full_performance_bit(fp), .main_clk_en(mce),
		.osc_overshoot(ovs), .sub_clock_fast(sfast), .cpu_hold(hold),
		.restore_ready(rdy), .supervisor_reset(srst));

	// 100 MHz clock
	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	task cmp_bit(input logic got, input logic exp);
		checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task cmp_cnt(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task summarize;
		if (err_count == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// watchdog: whole run is well under 10000 cycles
	initial
	begin
		#200000;
		err_count++;
		summarize();
	end

	// time of the first supervisor reset pulse after a level change
	task raise(input logic [1:0] to);
		first = 0;
		lvl = to;
		@(posedge ref_clk);
		for (k = 1; k <= 400; k++)
		begin
			@(negedge ref_clk);
			if (srst === 1'b1 && first == 0)
				first = k;
		end
	endtask

	initial
	begin
		err_count = 0;
		checks = 0;
		rst_b = 1'b0;
		lpm_wake = 1'b0;
		fp = 1'b0;
		xt2 = 1'b0;
		lvl = 2'h0;
		div = 3'h0;
		repeat (10) @(negedge ref_clk);
		// outputs quiet in reset, ready high, enable follows div 0
		cmp_bit(ovs | sfast | hold | srst, 1'b0);
		cmp_bit(rdy, 1'b1);
		cmp_bit(mce, 1'b1);
		repeat (10) @(negedge ref_clk);
		rst_b = 1'b1;
		repeat (3) @(negedge ref_clk);
		// ordinary wake-ups, one per row
		foreach (rows[i])
		begin
			lvl = rows[i][0];
			fp = rows[i][1];
			xt2 = rows[i][2];
			div = rows[i][3];
			repeat (2) @(negedge ref_clk);
			n_ovs = 0;
			n_sf = 0;
			n_hold = 0;
			n_pls = 0;
			rdy_k = 0;
			// a re-wake at k 99 reloads the window after 99 cycles
			exp_ovs = lpg_pkg::OVS_CYC + (rows[i][4] ? 99 : 0);
			// ready lands within one divider period of this cycle
			exp_lo = rows[i][5] + ((rows[i][6] - 1) << rows[i][3]) + 2;
			lpm_wake = 1'b1;
			@(posedge ref_clk);
			for (k = 1; k <= 1200; k++)
			begin
				@(negedge ref_clk);
				lpm_wake = (rows[i][4] == 1 && k == 99);
				if (k == 1)
				begin
					cmp_bit(rdy, 1'b0);
					cmp_bit(sfast, !rows[i][2]);
				end
				if (rdy === 1'b1 && rdy_k == 0)
					rdy_k = k;
				n_ovs += (ovs === 1'b1);
				n_sf += (sfast === 1'b1);
				n_hold += (hold === 1'b1);
				n_pls += (mce === 1'b1 && hold === 1'b0 && rdy === 1'b0);
			end
			cmp_cnt(n_ovs, exp_ovs);
			cmp_cnt(n_sf, rows[i][2] ? 0 : exp_ovs);
			cmp_cnt(n_hold, rows[i][5]);
			cmp_cnt(n_pls, rows[i][6]);
			cmp_bit(rdy, 1'b1);
			cmp_bit(rdy_k >= exp_lo
				&& rdy_k < exp_lo + (1 << rows[i][3]), 1'b1);
			cmp_bit(sfast, 1'b0);
		end
		// divider above five clamps to 2**5
		div = 3'h7;
		n_pls = 0;
		repeat (2) @(negedge ref_clk);
		repeat (320)
		begin
			@(negedge ref_clk);
			n_pls += (mce === 1'b1);
		end
		cmp_cnt(n_pls, 10);
		// raise under full performance trips the supervisor
		div = 3'h0;
		fp = 1'b1;
		lvl = 2'h0;
		repeat (400) @(negedge ref_clk);
		raise(2'h2);
		cmp_cnt(first, 201);
		// normal mode settles slowly enough, no reset
		fp = 1'b0;
		raise(2'h3);
		cmp_cnt(first, 0);
		summarize();
	end
endmodule

`default_nettype wire
